// [pkg/airs_params.svh]
`ifndef AIRS_PARAMS_SVH
`define AIRS_PARAMS_SVH
// Register word indices (byte address = 4 * index)
`define AIRS_IDX_INSEL    4'h7
`define AIRS_IDX_CTRLB    4'h3
`define AIRS_IDX_ACTIVE   4'h8
`define AIRS_IDX_STATUS   4'h9
`define AIRS_IDX_MASK     4'hA
`define AIRS_IDX_RESULT   4'hB
`define AIRS_INSEL_RST    8'h00
`define AIRS_CTRLB_RST    8'h00
// Field positions
`define AIRS_REF_LO_HI    7
`define AIRS_REF_LO_LO    6
`define AIRS_ALIGN_BIT    5
`define AIRS_CHAN_MSB_BIT 3
`define AIRS_REF_HI_BIT   4
`define AIRS_GAIN_SEL_BIT 6
// Status bits
`define AIRS_ST_DONE      0
`define AIRS_ST_REFCHG    1
// Conversion lengths in converter clock cycles
`define AIRS_CONV_NORMAL  5'd13
`define AIRS_CONV_LONG    5'd25
// Channel codes
`define AIRS_CH_SE_LAST   6'h0A
`define AIRS_CH_BANDGAP   6'h1E
`define AIRS_CH_GROUND    6'h1F
`define AIRS_CH_TEMP      6'h3F
`endif

// [pkg/airs_pkg.sv]
package airs_pkg;
  typedef enum logic [2:0] {
    AIRS_REF_SUPPLY, AIRS_REF_EXT, AIRS_REF_1V1, AIRS_REF_RSVD, AIRS_REF_2V56, AIRS_REF_2V56_BYP
  } airs_ref_type;
  typedef enum logic [2:0] {
    AIRS_IN_SINGLE, AIRS_IN_DIFF, AIRS_IN_BANDGAP, AIRS_IN_GROUND, AIRS_IN_TEMP
  } airs_in_type;
  typedef enum logic [1:0] {
    AIRS_GAIN_NONE, AIRS_GAIN_1X, AIRS_GAIN_8X, AIRS_GAIN_20X_32X
  } airs_gain_raw_type;
  typedef enum logic [2:0] {
    AIRS_G_NONE, AIRS_G_1, AIRS_G_8, AIRS_G_20, AIRS_G_32
  } airs_gain_type;
endpackage : airs_pkg

// [design/airs_chan_decode.sv]
`timescale 1ns/100ps
`include "airs_params.svh"
module airs_chan_decode (
  input  wire logic [5:0]            code_i,    // Channel code
  input  wire logic                  boost_i,   // Gain boost select
  output airs_pkg::airs_in_type      kind_o,    // Input kind
  output logic [3:0]                 pos_o,     // Positive / single input
  output logic [3:0]                 neg_o,     // Negative input
  output airs_pkg::airs_gain_type    gain_o     // Applied gain
);
  import airs_pkg::*;
  logic [3:0] p;
  logic [3:0] n;
  logic       hi;
  // Table lookup of pair and gain class
  always_comb begin
    p  = 4'h0;
    n  = 4'h0;
    hi = 1'b1;
    kind_o = AIRS_IN_DIFF;
    unique case (code_i)
      6'h0B: begin p = 4'h0; n = 4'h1; end
      6'h0C: begin p = 4'h0; n = 4'h1; hi = 1'b0; end
      6'h0D: begin p = 4'h1; n = 4'h1; end
      6'h0E: begin p = 4'h2; n = 4'h1; end
      6'h0F: begin p = 4'h2; n = 4'h1; hi = 1'b0; end
      6'h10: begin p = 4'h2; n = 4'h3; hi = 1'b0; end
      6'h11: begin p = 4'h3; n = 4'h3; end
      6'h12: begin p = 4'h4; n = 4'h3; end
      6'h13: begin p = 4'h4; n = 4'h3; hi = 1'b0; end
      6'h14: begin p = 4'h4; n = 4'h5; end
      6'h15: begin p = 4'h4; n = 4'h5; hi = 1'b0; end
      6'h16: begin p = 4'h5; n = 4'h5; end
      6'h17: begin p = 4'h6; n = 4'h5; end
      6'h18: begin p = 4'h6; n = 4'h5; hi = 1'b0; end
      6'h19: begin p = 4'h8; n = 4'h9; end
      6'h1A: begin p = 4'h8; n = 4'h9; hi = 1'b0; end
      6'h1B: begin p = 4'h9; n = 4'h9; end
      6'h1C: begin p = 4'hA; n = 4'h9; end
      6'h1D: begin p = 4'hA; n = 4'h9; hi = 1'b0; end
      `AIRS_CH_BANDGAP: kind_o = AIRS_IN_BANDGAP;
      `AIRS_CH_GROUND: kind_o = AIRS_IN_GROUND;
      6'h20, 6'h21: begin p = 4'h0; n = 4'h1; hi = ~code_i[0]; end
      6'h22, 6'h23: begin p = 4'h1; n = 4'h0; hi = ~code_i[0]; end
      6'h24, 6'h25: begin p = 4'h1; n = 4'h2; hi = ~code_i[0]; end
      6'h26, 6'h27: begin p = 4'h2; n = 4'h1; hi = ~code_i[0]; end
      6'h28, 6'h29: begin p = 4'h2; n = 4'h0; hi = ~code_i[0]; end
      6'h2A, 6'h2B: begin p = 4'h0; n = 4'h2; hi = ~code_i[0]; end
      6'h2C, 6'h2D: begin p = 4'h4; n = 4'h5; hi = ~code_i[0]; end
      6'h2E, 6'h2F: begin p = 4'h5; n = 4'h4; hi = ~code_i[0]; end
      6'h30, 6'h31: begin p = 4'h5; n = 4'h6; hi = ~code_i[0]; end
      6'h32, 6'h33: begin p = 4'h6; n = 4'h5; hi = ~code_i[0]; end
      6'h34, 6'h35: begin p = 4'h6; n = 4'h4; hi = ~code_i[0]; end
      6'h36, 6'h37: begin p = 4'h4; n = 4'h6; hi = ~code_i[0]; end
      6'h38, 6'h39: begin p = 4'h0; n = 4'h0; hi = ~code_i[0]; end
      6'h3A: begin p = 4'h1; n = 4'h1; end
      6'h3B: begin p = 4'h2; n = 4'h2; end
      6'h3C: begin p = 4'h4; n = 4'h4; end
      6'h3D: begin p = 4'h5; n = 4'h5; end
      6'h3E: begin p = 4'h6; n = 4'h6; end
      `AIRS_CH_TEMP: begin kind_o = AIRS_IN_TEMP; p = 4'hB; end
      default: begin
        kind_o = AIRS_IN_SINGLE;
        p      = code_i[3:0];
      end
    endcase
  end
  always_comb begin
    pos_o = p;
    neg_o = n;
    if (kind_o != AIRS_IN_DIFF) begin
      gain_o = AIRS_G_NONE;
    end else if (hi) begin
      // Boost only on upper half codes
      gain_o = (boost_i && code_i[5]) ? AIRS_G_32 : AIRS_G_20;
    end else begin
      gain_o = (boost_i && code_i[5]) ? AIRS_G_8 : AIRS_G_1;
    end
  end
endmodule : airs_chan_decode

// [design/airs_align.sv]
`timescale 1ns/100ps
module airs_align (
  input  wire logic [9:0]  result_i,  // Raw 10-bit result
  input  wire logic        left_i,    // Left align select
  output logic [15:0]      data_o     // Data register pair
);
  always_comb begin
    if (left_i) begin
      data_o = {result_i, 6'h00};
    end else begin
      data_o = {6'h00, result_i};
    end
  end
endmodule : airs_align

// [design/airs_top.sv]
`timescale 1ns/100ps
`include "airs_params.svh"
//
// Contract
// - Reference selector is high bit from ctrl B plus register bits 7:6.
// - 00 picks supply, 01 external pin; high bit ignored for both.
// - 010 picks internal 1.1V; 011 is reserved.
// - 110 internal 2.56V, pin off; 111 same with pin bypass.
// - Reference writes during conversion apply after completion flag sets.
// - After any reference change next conversion lasts 25 converter clocks.
// - Bit 5 one gives left aligned result, zero right aligned.
// - Alignment change reformats data registers immediately, even mid conversion.
// - Six-bit channel code from bits 4:0 plus msb picks inputs.
// - Differential codes also choose the gain stage setting.
// - Channel changes during conversion wait for completion; old channel used.
// - Codes tying one pin to both inputs are supported for offset.
// - Code 111111 selects the temperature sensor as single-ended.
// - Gain boost turns 20x into 32x and 1x into 8x, only for codes with the msb set.
// - Control B bit 3 is channel code msb.
// - Completion flag sets once result registers hold the new value.
//
module airs_top (
  input  wire logic                  clk_i,       // 200 MHz clock
  input  wire logic                  rst_i,       // Sync reset, active high
  input  wire logic [5:0]            wb_adr_i,    // Byte address
  input  wire logic [31:0]           wb_dat_i,    // Write data
  input  wire logic [3:0]            wb_sel_i,    // Byte enables
  input  wire logic                  wb_we_i,     // Write enable
  input  wire logic                  wb_cyc_i,    // Cycle
  input  wire logic                  wb_stb_i,    // Strobe
  output logic [31:0]                wb_dat_o,    // Read data
  output logic                       wb_ack_o,    // Acknowledge
  input  wire logic                  conv_busy_i, // Converter running
  input  wire logic                  conv_end_i,  // Result written pulse
  input  wire logic [9:0]            conv_res_i,  // Converter result
  output logic                       conv_long_o, // Next conversion 25 clocks
  output airs_pkg::airs_ref_type     ref_sel_o,   // Active reference
  output logic                       ext_ref_pin_en_o, // Reference on pin
  output airs_pkg::airs_in_type      in_kind_o,   // Active input kind
  output logic [3:0]                 in_pos_o,    // Positive input index
  output logic [3:0]                 in_neg_o,    // Negative input index
  output airs_pkg::airs_gain_type    gain_o,      // Active gain
  output logic [15:0]                data_o,      // Aligned data pair
  output logic                       irq_o        // Interrupt level
);
  import airs_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  insel_r,  insel_nxt;
  logic [7:0]  ctrlb_r,  ctrlb_nxt;
  logic [2:0]  ext_ref_pin_r,   ext_ref_pin_nxt;
  logic [5:0]  achan_r,  achan_nxt;
  logic        aboost_r, aboost_nxt;
  logic        long_r,   long_nxt;
  logic        busy_q_r;
  logic [1:0]  stat_r,   stat_nxt;
  logic [1:0]  mask_r,   mask_nxt;
  logic [9:0]  res_r,    res_nxt;
  logic        ack_r,    ack_nxt;
  logic [31:0] rdat_r,   rdat_nxt;
  logic        irq_r,    irq_nxt;
  logic [3:0]  ptr_pos_r, ptr_neg_r;
  airs_ref_type  ref_r;
  airs_in_type   kind_r, kind_w;
  airs_gain_type gain_r, gain_w;
  logic [15:0] data_r, data_w;
  logic [3:0]  pos_w, neg_w;
  logic        pin_r, pin_nxt;
  logic        wr, rd;
  logic [3:0]  idx;
  logic [2:0]  ref_req;
  logic        ref_chg;
  airs_ref_type ref_nxt;
  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign idx = wb_adr_i[5:2];
  assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r & wb_sel_i[0];
  assign rd  = wb_cyc_i & wb_stb_i & ~ack_r;
  assign ref_req = {ctrlb_nxt[`AIRS_REF_HI_BIT], insel_nxt[`AIRS_REF_LO_HI:`AIRS_REF_LO_LO]};
  assign ref_chg = (ref_req != {ctrlb_r[`AIRS_REF_HI_BIT], insel_r[`AIRS_REF_LO_HI:`AIRS_REF_LO_LO]});
  // Register writes
  always_comb begin
    insel_nxt = insel_r;
    ctrlb_nxt = ctrlb_r;
    mask_nxt  = mask_r;
    if (wr && idx == `AIRS_IDX_INSEL) begin
      insel_nxt = wb_dat_i[7:0];
    end
    if (wr && idx == `AIRS_IDX_CTRLB) begin
      ctrlb_nxt = {wb_dat_i[7:6], 1'b0, wb_dat_i[4:0]};
    end
    if (wr && idx == `AIRS_IDX_MASK) begin
      mask_nxt = wb_dat_i[1:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Active selection, deferred while busy
  always_comb begin
    ext_ref_pin_nxt   = ext_ref_pin_r;
    achan_nxt  = achan_r;
    aboost_nxt = aboost_r;
    long_nxt   = long_r;
    res_nxt    = res_r;
    stat_nxt   = stat_r;
    if (ref_chg) begin
      long_nxt = 1'b1;
    end else if (conv_busy_i && !busy_q_r) begin
      // Converter took the flag at its start
      long_nxt = 1'b0;
    end
    if (!conv_busy_i || conv_end_i) begin
      ext_ref_pin_nxt   = ref_req;
      achan_nxt  = {ctrlb_nxt[`AIRS_CHAN_MSB_BIT], insel_nxt[4:0]};
      aboost_nxt = ctrlb_nxt[`AIRS_GAIN_SEL_BIT];
    end
    if (conv_end_i) begin
      res_nxt = conv_res_i;
    end
    if (wr && idx == `AIRS_IDX_STATUS) begin
      stat_nxt = stat_r & ~wb_dat_i[1:0];
    end
    if (conv_end_i) begin
      stat_nxt[`AIRS_ST_DONE] = 1'b1;
    end
    if (ref_chg) begin
      stat_nxt[`AIRS_ST_REFCHG] = 1'b1;
    end
  end
  // Reference decode
  always_comb begin
    pin_nxt = 1'b0;
    unique case (ext_ref_pin_r[1:0])
      2'b00: ref_nxt = AIRS_REF_SUPPLY;
      2'b01: ref_nxt = AIRS_REF_EXT;
      2'b10: ref_nxt = ext_ref_pin_r[2] ? AIRS_REF_2V56 : AIRS_REF_1V1;
      default: begin
        ref_nxt = ext_ref_pin_r[2] ? AIRS_REF_2V56_BYP : AIRS_REF_RSVD;
        pin_nxt = ext_ref_pin_r[2];
      end
    endcase
  end
  airs_chan_decode u_dec (
    .code_i  (achan_r),
    .boost_i (aboost_r),
    .kind_o  (kind_w),
    .pos_o   (pos_w),
    .neg_o   (neg_w),
    .gain_o  (gain_w)
  );
  airs_align u_align (
    .result_i (res_nxt),
    .left_i   (insel_nxt[`AIRS_ALIGN_BIT]),
    .data_o   (data_w)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Bus answer and interrupt
  always_comb begin
    ack_nxt  = rd;
    rdat_nxt = 32'h0000_0000;
    irq_nxt  = |(stat_nxt & mask_nxt);
    if (rd) begin
      unique case (idx)
        `AIRS_IDX_INSEL:  rdat_nxt = {24'h000000, insel_r};
        `AIRS_IDX_CTRLB:  rdat_nxt = {24'h000000, ctrlb_r};
        `AIRS_IDX_ACTIVE: rdat_nxt = {22'h000000, long_r, ext_ref_pin_r, achan_r};
        `AIRS_IDX_STATUS: rdat_nxt = {30'h00000000, stat_r};
        `AIRS_IDX_MASK:   rdat_nxt = {30'h00000000, mask_r};
        `AIRS_IDX_RESULT: rdat_nxt = {16'h0000, data_r};
        default:          rdat_nxt = 32'h0000_0000;
      endcase
    end
  end
  // State registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      insel_r   <= `AIRS_INSEL_RST;
      ctrlb_r   <= `AIRS_CTRLB_RST;
      ext_ref_pin_r    <= 3'h0;
      achan_r   <= 6'h00;
      aboost_r  <= 1'b0;
      long_r    <= 1'b0;
      busy_q_r  <= 1'b0;
      stat_r    <= 2'h0;
      mask_r    <= 2'h0;
      res_r     <= 10'h000;
      ack_r     <= 1'b0;
      rdat_r    <= 32'h0000_0000;
      irq_r     <= 1'b0;
      ref_r     <= AIRS_REF_SUPPLY;
      pin_r     <= 1'b0;
      kind_r    <= AIRS_IN_SINGLE;
      gain_r    <= AIRS_G_NONE;
      ptr_pos_r <= 4'h0;
      ptr_neg_r <= 4'h0;
      data_r    <= 16'h0000;
    end else begin
      insel_r   <= insel_nxt;
      ctrlb_r   <= ctrlb_nxt;
      ext_ref_pin_r    <= ext_ref_pin_nxt;
      achan_r   <= achan_nxt;
      aboost_r  <= aboost_nxt;
      long_r    <= long_nxt;
      busy_q_r  <= conv_busy_i;
      stat_r    <= stat_nxt;
      mask_r    <= mask_nxt;
      res_r     <= res_nxt;
      ack_r     <= ack_nxt;
      rdat_r    <= rdat_nxt;
      irq_r     <= irq_nxt;
      ref_r     <= ref_nxt;
      pin_r     <= pin_nxt;
      kind_r    <= kind_w;
      gain_r    <= gain_w;
      ptr_pos_r <= pos_w;
      ptr_neg_r <= neg_w;
      data_r    <= data_w;
    end
  end
  // Outputs
  assign wb_dat_o         = rdat_r;
  assign wb_ack_o         = ack_r;
  assign conv_long_o      = long_r;
  assign ref_sel_o        = ref_r;
  assign ext_ref_pin_en_o = pin_r;
  assign in_kind_o        = kind_r;
  assign in_pos_o         = ptr_pos_r;
  assign in_neg_o         = ptr_neg_r;
  assign gain_o           = gain_r;
  assign data_o           = data_r;
  assign irq_o            = irq_r;
endmodule : airs_top

// [dv/airs_props.sv]
`timescale 1ns/100ps
module airs_props
  import airs_pkg::*;
(
  input  wire logic              clk_i,            // Clock
  input  wire logic              rst_i,            // Sync reset
  input  wire logic              wb_cyc_i,         // Cycle
  input  wire logic              wb_stb_i,         // Strobe
  input  wire logic [31:0]       wb_dat_o,         // Read data
  input  wire logic              wb_ack_o,         // Acknowledge
  input  wire logic              conv_busy_i,      // Converter running
  input  wire logic              conv_end_i,       // Result pulse
  input  wire logic [9:0]        conv_res_i,       // Result
  input  wire logic              conv_long_o,      // Long conversion
  input  wire airs_pkg::airs_ref_type  ref_sel_o,  // Active reference
  input  wire logic              ext_ref_pin_en_o, // Reference on pin
  input  wire airs_pkg::airs_in_type   in_kind_o,  // Input kind
  input  wire logic [3:0]        in_pos_o,         // Positive input
  input  wire logic [3:0]        in_neg_o,         // Negative input
  input  wire airs_pkg::airs_gain_type gain_o,     // Gain
  input  wire logic [15:0]       data_o,           // Aligned data
  input  wire logic              irq_o             // Interrupt
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  // Steps of a bus request and of a held conversion
  sequence wb_take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence busy_hold_s;
    (conv_busy_i && !conv_end_i) [*4];
  endsequence
  ////////////////////////////////////////////////////////////////
  AST_ACK_NEXT: assert property (wb_take_s |=> wb_ack_o) else $error("ack not one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  AST_RD_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) else $error("upper read bits set");
  AST_HOLD_SEL: assert property (busy_hold_s |-> $stable(ref_sel_o) && $stable(in_pos_o) &&
    $stable(in_neg_o) && $stable(gain_o)) else $error("selection moved during conversion");
  AST_PIN_BYP: assert property (ext_ref_pin_en_o == (ref_sel_o == AIRS_REF_2V56_BYP))
    else $error("pin enable wrong for reference");
  AST_GAIN_DIFF: assert property ((in_kind_o == AIRS_IN_DIFF) == (gain_o != AIRS_G_NONE))
    else $error("gain without differential input");
  AST_TEMP_POS: assert property (in_kind_o == AIRS_IN_TEMP |-> in_pos_o == 4'hB)
    else $error("temperature input index wrong");
  AST_SINGLE_POS: assert property (in_kind_o == AIRS_IN_SINGLE |-> in_pos_o <= 4'hA)
    else $error("single input index out of range");
  AST_ALIGN: assert property (conv_end_i |=> data_o == {$past(conv_res_i), 6'h00} ||
    data_o == {6'h00, $past(conv_res_i)}) else $error("data not loaded after result");
  AST_RESET: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !irq_o && !conv_long_o &&
    ref_sel_o == AIRS_REF_SUPPLY) else $error("outputs not cleared by reset");
endmodule : airs_props

// [dv/airs_conv_model.sv]
`timescale 1ns/100ps
module airs_conv_model (
  input  wire logic       clk_i,   // Clock
  input  wire logic       rst_i,   // Sync reset
  input  wire logic       start_i, // Start pulse
  input  wire logic       long_i,  // Extended conversion request
  input  wire logic [9:0] val_i,   // Result to deliver
  output logic            busy_o,  // Converting
  output logic            end_o,   // Result pulse
  output logic [9:0]      res_o    // Result bus
);
  logic [4:0] cnt_r;
  logic [4:0] len_r;
  assign res_o = end_o ? val_i : ~val_i;
  // length fixed at start, 25 or 13
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      end_o  <= 1'b0;
      cnt_r  <= 5'h00;
      len_r  <= 5'h00;
    end else if (start_i && !busy_o) begin
      busy_o <= 1'b1;
      cnt_r  <= 5'h01;
      len_r  <= long_i ? 5'h19 : 5'h0D;
    end else if (busy_o) begin
      cnt_r <= cnt_r + 5'h01;
      end_o <= (cnt_r == len_r - 5'h01);
      if (end_o) begin
        busy_o <= 1'b0;
      end
    end
  end
endmodule : airs_conv_model

// [dv/airs_top_bench.sv]
`timescale 1ns/100ps
module airs_top_bench;
  import airs_pkg::*;
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic [5:0]    wb_adr_i = 6'h00;
  logic [31:0]   wb_dat_i = 32'h0;
  logic [3:0]    wb_sel_i = 4'h0;
  logic          wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, start = 1'b0;
  logic [9:0]    val = 10'h000;
  logic [31:0]   wb_dat_o, q;
  logic          wb_ack_o, conv_busy_i, conv_end_i, conv_long_o, ext_ref_pin_en_o, irq_o;
  logic [9:0]    conv_res_i, v;
  airs_ref_type  ref_sel_o;
  airs_in_type   in_kind_o;
  airs_gain_type gain_o;
  logic [3:0]    in_pos_o, in_neg_o;
  logic [15:0]   data_o;
  logic [5:0]    c;
  logic          b;
  int            fail_count = 0, n_checks = 0, cyc_n = 0;
  localparam logic [5:0] PN_C [6] = '{6'h0D, 6'h38, 6'h3E, 6'h0B, 6'h22, 6'h2A};
  localparam logic [7:0] PN_V [6] = '{8'h11, 8'h00, 8'h66, 8'h01, 8'h10, 8'h02};
  ////////////////////////////////////////////////////////////////
  airs_top u_airs_top (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .conv_busy_i, .conv_end_i, .conv_res_i, .conv_long_o, .ref_sel_o,
    .ext_ref_pin_en_o, .in_kind_o, .in_pos_o, .in_neg_o, .gain_o, .data_o, .irq_o);
  airs_conv_model u_airs_conv_model (.clk_i, .rst_i, .start_i(start), .long_i(conv_long_o), .val_i(val),
    .busy_o(conv_busy_i), .end_o(conv_end_i), .res_o(conv_res_i));
  // Clock and hang guard
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////
  // Comparisons
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_port(input logic [15:0] got, input logic [15:0] exp);
    chk_reg({16'h0000, got}, {16'h0000, exp});
  endtask : chk_port
  // Classic single bus cycle
  task automatic wb(input logic [3:0] idx, input logic w, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk_i);
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    wb_we_i  <= w;
    wb_sel_i <= s;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic rd(input logic [3:0] idx, input logic [7:0] e);
    wb(idx, 1'b0, 8'h00, 4'hF);
    chk_reg(q, {24'h000000, e});
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask : settle
  // Reference, channel, boost and alignment in both registers
  task automatic set_sel(input logic [2:0] r, input logic [5:0] ch, input logic bo, input logic al);
    wb(4'h3, 1'b1, {1'b0, bo, 1'b0, r[2], ch[5], 3'b000}, 4'hF);
    wb(4'h7, 1'b1, {r[1:0], al, ch[4:0]}, 4'hF);
  endtask : set_sel
  task automatic start_conv(input logic [9:0] d);
    @(posedge clk_i);
    val   <= d;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
  endtask : start_conv
  task automatic wait_done;
    while (conv_end_i !== 1'b1) @(posedge clk_i);
    settle();
  endtask : wait_done
  ////////////////////////////////////////////////////////////////
  // Expected values
  function automatic airs_ref_type exp_ref(input logic [2:0] r);
    if (!r[1]) return r[0] ? AIRS_REF_EXT : AIRS_REF_SUPPLY;
    return r[2] ? (r[0] ? AIRS_REF_2V56_BYP : AIRS_REF_2V56) : AIRS_REF_1V1;
  endfunction : exp_ref
  function automatic airs_in_type exp_kind(input logic [5:0] ch);
    if (ch <= 6'h0A) return AIRS_IN_SINGLE;
    if (ch == 6'h1E) return AIRS_IN_BANDGAP;
    if (ch == 6'h1F) return AIRS_IN_GROUND;
    if (ch == 6'h3F) return AIRS_IN_TEMP;
    return AIRS_IN_DIFF;
  endfunction : exp_kind
  function automatic airs_gain_type exp_gain(input logic [5:0] ch, input logic bo);
    logic one;
    if (exp_kind(ch) != AIRS_IN_DIFF) return AIRS_G_NONE;
    one = ch[5] ? (ch <= 6'h37 ? ch[0] : ch == 6'h39) : (ch inside {6'h0C, 6'h0F, 6'h10, 6'h13, 6'h15,
      6'h18, 6'h1A, 6'h1D});
    if (ch[5] && bo) return one ? AIRS_G_8 : AIRS_G_32;
    return one ? AIRS_G_1 : AIRS_G_20;
  endfunction : exp_gain
  task automatic chk_chan(input logic [5:0] ch, input logic bo);
    set_sel(3'b000, ch, bo, 1'b0);
    settle();
    chk_port({10'h000, in_kind_o, gain_o}, {10'h000, exp_kind(ch), exp_gain(ch, bo)});
    if (ch <= 6'h0A) chk_port({12'h000, in_pos_o}, {10'h000, ch});
  endtask : chk_chan
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(86756));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h7, 8'h00);
    rd(4'h3, 8'h00);
    wb(4'hC, 1'b1, 8'hFF, 4'hF);
    rd(4'hC, 8'h00);
    wb(4'h7, 1'b1, 8'hFF, 4'h0);
    rd(4'h7, 8'h00);
    $display("test registers done");
    for (int r = 0; r < 8; r++) begin
      if (r != 3) begin
        set_sel(r[2:0], 6'h00, 1'b0, 1'b0);
        settle();
        chk_port({12'h000, ref_sel_o, ext_ref_pin_en_o}, {12'h000, exp_ref(r[2:0]), r == 7});
        rd(4'h7, {r[1:0], 6'h00});
        rd(4'h3, {3'b000, r[2], 4'h0});
      end
    end
    $display("test reference done");
    for (int i = 0; i < 6; i++) begin
      chk_chan(PN_C[i], 1'b0);
      chk_port({8'h00, in_pos_o, in_neg_o}, {8'h00, PN_V[i]});
    end
    foreach (PN_C[i]) chk_chan({2'b00, 4'hA} + 6'(i * 16'h0), 1'b0);
    chk_chan(6'h1E, 1'b0);
    chk_chan(6'h1F, 1'b1);
    chk_chan(6'h3F, 1'b0);
    for (int i = 0; i < 24; i++) begin
      c = 6'($urandom);
      b = 1'($urandom);
      chk_chan(c, b);
    end
    $display("test channels done");
    set_sel(3'b000, 6'h01, 1'b0, 1'b0);
    settle();
    wb(4'hA, 1'b1, 8'h01, 4'hF);
    wb(4'h9, 1'b1, 8'h03, 4'hF);
    v = 10'($urandom);
    start_conv(v);
    wait_done();
    chk_port(data_o, {6'h00, v});
    wb(4'hB, 1'b0, 8'h00, 4'hF);
    chk_reg(q, {22'h000000, v});
    chk_port({15'h0000, conv_long_o}, 16'h0000);
    chk_port({15'h0000, irq_o}, 16'h0001);
    rd(4'h9, 8'h01);
    wb(4'h9, 1'b1, 8'h01, 4'hF);
    settle();
    chk_port({15'h0000, irq_o}, 16'h0000);
    $display("test conversion done");
    start_conv(10'($urandom));
    set_sel(3'b001, 6'h0D, 1'b0, 1'b1);
    settle();
    chk_port(data_o, {v, 6'h00});
    chk_port({12'h000, ref_sel_o, 1'b0}, {12'h000, AIRS_REF_SUPPLY, 1'b0});
    chk_port({8'h00, in_pos_o, in_neg_o}, 16'h0010);
    wait_done();
    chk_port({12'h000, ref_sel_o, 1'b0}, {12'h000, AIRS_REF_EXT, 1'b0});
    chk_port({8'h00, in_pos_o, in_neg_o}, 16'h0011);
    chk_port({15'h0000, conv_long_o}, 16'h0001);
    chk_port(data_o, {val, 6'h00});
    start_conv(10'($urandom));
    wait_done();
    chk_port({15'h0000, conv_long_o}, 16'h0000);
    $display("test deferral done");
    give_verdict();
  end
endmodule : airs_top_bench
bind airs_top airs_props u_airs_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
  .conv_busy_i, .conv_end_i, .conv_res_i, .conv_long_o, .ref_sel_o, .ext_ref_pin_en_o, .in_kind_o,
  .in_pos_o, .in_neg_o, .gain_o, .data_o, .irq_o);
